// >>> pif_pkg.sv
// constants and types for the peripheral interrupt flag block
package pif_pkg;
   // --------------------------------------------------------------
   // register map, byte addresses within the decoded window
   // --------------------------------------------------------------
   localparam int PIF_DEC_W = 12;
   localparam logic [11:0] PIF_OFS_THREE = 12'h000;
   localparam logic [11:0] PIF_OFS_FOUR = 12'h004;
   localparam logic [11:0] PIF_OFS_FIVE = 12'h008;
   localparam logic [11:0] PIF_OFS_SIX = 12'h00c;
   localparam int PIF_REG_N = 4;
   localparam int PIF_FLAG_W = 8;
   localparam int PIF_CAPCOMP_N = 10;
   localparam logic [7:0] PIF_FLAGS_RESET = 8'h00;
   // --------------------------------------------------------------
   // writable sticky positions per register (listed six, five, four, three)
   // --------------------------------------------------------------
   localparam logic [3:0][7:0] PIF_STICKY_MASK =
      {8'h07, 8'h77, 8'hff, 8'h8f};
   // --------------------------------------------------------------
   // field positions
   // --------------------------------------------------------------
   localparam int PIF_B3_T5GATE = 7;
   localparam int PIF_B3_SEG = 6;
   localparam int PIF_B3_U2RX = 5;
   localparam int PIF_B3_U2TX = 4;
   localparam int PIF_B3_CHARGE = 3;
   localparam int PIF_B3_CAL = 0;
   localparam int PIF_B5_OOR = 6;
   localparam int PIF_B5_LOCK = 5;
   localparam int PIF_B5_T8 = 4;
   localparam int PIF_B5_T6 = 2;
   localparam int PIF_B5_T5OVF = 1;
   localparam int PIF_B5_T4 = 0;
   localparam int PIF_B6_U4RX = 7;
   localparam int PIF_B6_U4TX = 6;
   localparam int PIF_B6_U3RX = 5;
   localparam int PIF_B6_U3TX = 4;
   // --------------------------------------------------------------
   // buffer flag slots and their hold time after an access
   // --------------------------------------------------------------
   localparam int PIF_UART_N = 6;
   localparam int PIF_U2RX = 0;
   localparam int PIF_U2TX = 1;
   localparam int PIF_U3RX = 2;
   localparam int PIF_U3TX = 3;
   localparam int PIF_U4RX = 4;
   localparam int PIF_U4TX = 5;
   localparam logic [1:0] PIF_HOLD_CYCLES = 2'h2;
   typedef enum logic [1:0]
   {
      PIF_ADDR = 2'b01,
      PIF_WDATA = 2'b10
   } pif_phase_t;
endpackage

// >>> pif_buffer_flag.sv
// flag that mirrors a buffer level and drops on a data access
`timescale 1ns/100ps
module pif_buffer_flag
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_level,
   input wire logic i_access,
   output logic o_flag
);
   import pif_pkg::*;
   // --------------------------------------------------------------
   // hold after access
   // --------------------------------------------------------------
   // the buffer's own level lags the access by a cycle or two, so the
   // flag stays down until the level drops or the hold expires
   logic [1:0] hold;
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         hold <= 2'h0;
      else if (i_access)
         hold <= PIF_HOLD_CYCLES;
      else if (!i_level)
         hold <= 2'h0;
      else if (hold != 2'h0)
         hold <= hold - 2'h1;
   end
   // --------------------------------------------------------------
   // flag
   // --------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_flag <= 1'b0;
      else
         o_flag <= i_level & ~i_access & (hold == 2'h0);
   end
endmodule // pif_buffer_flag

// >>> pif_flags.sv
// peripheral interrupt flag registers three to six behind ahb-lite
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module pif_flags
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   input wire logic i_seg_write_ok,
   input wire logic i_uart2_rx_full,
   input wire logic i_uart2_tx_empty,
   input wire logic i_uart3_rx_full,
   input wire logic i_uart3_tx_empty,
   input wire logic i_uart4_rx_full,
   input wire logic i_uart4_tx_empty,
   input wire logic i_uart2_rx_data_read,
   input wire logic i_uart2_tx_data_write,
   input wire logic i_uart3_rx_data_read,
   input wire logic i_uart3_tx_data_write,
   input wire logic i_uart4_rx_data_read,
   input wire logic i_uart4_tx_data_write,
   input wire logic i_charge_time_event,
   input wire logic [pif_pkg::PIF_CAPCOMP_N-1:0] i_capcomp_capture,
   input wire logic [pif_pkg::PIF_CAPCOMP_N-1:0] i_capcomp_match,
   input wire logic [pif_pkg::PIF_CAPCOMP_N-1:0] i_capcomp_pwm_mode,
   input wire logic i_tuning_out_of_range,
   input wire logic i_tuning_locked,
   input wire logic i_timer8_period_match,
   input wire logic i_timer6_period_match,
   input wire logic [2:0] i_comparator_event,
   input wire logic i_timer5_gate_event,
   input wire logic i_timer5_overflow,
   input wire logic i_timer4_period_match,
   input wire logic i_calendar_event,
   output logic [pif_pkg::PIF_FLAG_W-1:0] o_peripheral_flags_three,
   output logic [pif_pkg::PIF_FLAG_W-1:0] o_peripheral_flags_four,
   output logic [pif_pkg::PIF_FLAG_W-1:0] o_peripheral_flags_five,
   output logic [pif_pkg::PIF_FLAG_W-1:0] o_peripheral_flags_six
);
   import pif_pkg::*;

   // --------------------------------------------------------------
   // address decode
   // --------------------------------------------------------------
   function automatic logic [PIF_REG_N-1:0] reg_select
   (
      input logic [31:0] addr
   );
      logic [PIF_DEC_W-1:0] ofs;
      ofs = addr[PIF_DEC_W-1:0];
      reg_select = '0;
      if (addr[31:PIF_DEC_W] == '0)
      begin
         reg_select[0] = (ofs == PIF_OFS_THREE);
         reg_select[1] = (ofs == PIF_OFS_FOUR);
         reg_select[2] = (ofs == PIF_OFS_FIVE);
         reg_select[3] = (ofs == PIF_OFS_SIX);
      end
   endfunction

   // --------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // --------------------------------------------------------------
   logic addr_ok;
   logic [PIF_REG_N-1:0] rd_sel;
   pif_phase_t phase;
   logic [PIF_REG_N-1:0] wr_sel;
   logic [PIF_REG_N-1:0] wr_en;
   logic [PIF_FLAG_W-1:0] wbyte;
   logic [PIF_FLAG_W-1:0] image [PIF_REG_N];
   logic [PIF_FLAG_W-1:0] next_rbyte;

   assign addr_ok = i_hsel & i_hready & i_htrans[1];
   assign rd_sel = reg_select(i_haddr);
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign wbyte = i_hwdata[PIF_FLAG_W-1:0];

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         phase <= PIF_ADDR;
         wr_sel <= '0;
      end
      else if (addr_ok && i_hwrite)
      begin
         phase <= PIF_WDATA;
         wr_sel <= reg_select(i_haddr);
      end
      else
      begin
         phase <= PIF_ADDR;
         wr_sel <= '0;
      end
   end

   always_comb
   begin
      unique case (phase)
         PIF_ADDR: wr_en = '0;
         PIF_WDATA: wr_en = wr_sel;
         default: wr_en = '0;
      endcase
   end

   // read data is sampled at the address phase; a read right behind a
   // write to the same register sees the value before that write
   always_comb
   begin
      next_rbyte = '0;
      for (int r = 0; r < PIF_REG_N; r++)
         if (rd_sel[r])
            next_rbyte = next_rbyte | image[r];
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_hrdata <= 32'h0000_0000;
      else if (addr_ok && !i_hwrite)
         o_hrdata <= {24'h00_0000, next_rbyte};
   end

   // --------------------------------------------------------------
   // buffer flags of the serial ports
   // --------------------------------------------------------------
   logic [PIF_UART_N-1:0] uart_level;
   logic [PIF_UART_N-1:0] uart_access;
   logic [PIF_UART_N-1:0] uart_flag;

   assign uart_level[PIF_U2RX] = i_uart2_rx_full;
   assign uart_level[PIF_U2TX] = i_uart2_tx_empty;
   assign uart_level[PIF_U3RX] = i_uart3_rx_full;
   assign uart_level[PIF_U3TX] = i_uart3_tx_empty;
   assign uart_level[PIF_U4RX] = i_uart4_rx_full;
   assign uart_level[PIF_U4TX] = i_uart4_tx_empty;
   assign uart_access[PIF_U2RX] = i_uart2_rx_data_read;
   assign uart_access[PIF_U2TX] = i_uart2_tx_data_write;
   assign uart_access[PIF_U3RX] = i_uart3_rx_data_read;
   assign uart_access[PIF_U3TX] = i_uart3_tx_data_write;
   assign uart_access[PIF_U4RX] = i_uart4_rx_data_read;
   assign uart_access[PIF_U4TX] = i_uart4_tx_data_write;

   genvar g;
   generate
      for (g = 0; g < PIF_UART_N; g++)
      begin : g_uart
         pif_buffer_flag u_flag
         (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_level(uart_level[g]),
            .i_access(uart_access[g]),
            .o_flag(uart_flag[g])
         );
      end
   endgenerate

   // --------------------------------------------------------------
   // level flags
   // --------------------------------------------------------------
   logic seg_flag;
   logic lock_prev;
   logic lock_change;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         seg_flag <= 1'b0;
      else
         seg_flag <= i_seg_write_ok;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         lock_prev <= 1'b0;
      else
         lock_prev <= i_tuning_locked;
   end
   assign lock_change = i_tuning_locked ^ lock_prev;

   // --------------------------------------------------------------
   // sticky event flags
   // --------------------------------------------------------------
   logic [PIF_CAPCOMP_N-1:0] capcomp_set;
   logic [PIF_FLAG_W-1:0] set_vec [PIF_REG_N];
   logic [PIF_FLAG_W-1:0] lvl_vec [PIF_REG_N];
   logic [PIF_FLAG_W-1:0] sticky [PIF_REG_N];

   // pulse-width mode masks both capture and match
   assign capcomp_set = (i_capcomp_capture | i_capcomp_match)
      & ~i_capcomp_pwm_mode;

   // enables live elsewhere; the only gating here is pulse-width mode on capture and match
   always_comb
   begin
      set_vec[0] = '0;
      set_vec[0][PIF_B3_T5GATE] = i_timer5_gate_event;
      set_vec[0][PIF_B3_CHARGE] = i_charge_time_event;
      set_vec[0][2:1] = capcomp_set[1:0];
      set_vec[0][PIF_B3_CAL] = i_calendar_event;
      set_vec[1] = capcomp_set[PIF_CAPCOMP_N-1:2];
      set_vec[2] = '0;
      set_vec[2][PIF_B5_OOR] = i_tuning_out_of_range;
      set_vec[2][PIF_B5_LOCK] = lock_change;
      set_vec[2][PIF_B5_T8] = i_timer8_period_match;
      set_vec[2][PIF_B5_T6] = i_timer6_period_match;
      set_vec[2][PIF_B5_T5OVF] = i_timer5_overflow;
      set_vec[2][PIF_B5_T4] = i_timer4_period_match;
      set_vec[3] = '0;
      set_vec[3][2:0] = i_comparator_event;
   end

   always_comb
   begin
      lvl_vec[0] = '0;
      lvl_vec[0][PIF_B3_SEG] = seg_flag;
      lvl_vec[0][PIF_B3_U2RX] = uart_flag[PIF_U2RX];
      lvl_vec[0][PIF_B3_U2TX] = uart_flag[PIF_U2TX];
      lvl_vec[1] = '0;
      lvl_vec[2] = '0;
      lvl_vec[3] = '0;
      lvl_vec[3][PIF_B6_U4RX] = uart_flag[PIF_U4RX];
      lvl_vec[3][PIF_B6_U4TX] = uart_flag[PIF_U4TX];
      lvl_vec[3][PIF_B6_U3RX] = uart_flag[PIF_U3RX];
      lvl_vec[3][PIF_B6_U3TX] = uart_flag[PIF_U3TX];
   end

   generate
      for (g = 0; g < PIF_REG_N; g++)
      begin : g_reg
         // a set in the cycle of a clearing write wins
         always_ff @(posedge i_clk or posedge i_rst)
         begin
            if (i_rst)
               sticky[g] <= PIF_FLAGS_RESET;
            else
               sticky[g] <= ((wr_en[g] ? wbyte : sticky[g]) | set_vec[g])
                  & PIF_STICKY_MASK[g];
         end
         assign image[g] = sticky[g] | lvl_vec[g];
      end
   endgenerate

   assign o_peripheral_flags_three = image[0];
   assign o_peripheral_flags_four = image[1];
   assign o_peripheral_flags_five = image[2];
   assign o_peripheral_flags_six = image[3];

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_read_addr(logic [11:0] ofs);
      addr_ok && !i_hwrite && i_haddr == {20'h0_0000, ofs};
   endsequence

   sequence s_write_zero(logic [11:0] ofs);
      addr_ok && i_hwrite && i_haddr == {20'h0_0000, ofs}
         ##1 wbyte == 8'h00;
   endsequence

   a_seg_ready_follow: assert property
      (o_peripheral_flags_three[PIF_B3_SEG] == $past(i_seg_write_ok))
      else $error("segment ready flag does not follow write permission");

   a_u2tx_write_clear: assert property
      (i_uart2_tx_data_write |=> !o_peripheral_flags_three[PIF_B3_U2TX])
      else $error("uart2 transmit flag not cleared by data write");

   a_u3rx_read_clear: assert property
      (i_uart3_rx_data_read |=> !o_peripheral_flags_six[PIF_B6_U3RX])
      else $error("uart3 receive flag not cleared by data read");

   a_u4tx_empty_show: assert property
      ((i_uart4_tx_empty && !i_uart4_tx_data_write) [*4]
         |=> o_peripheral_flags_six[PIF_B6_U4TX])
      else $error("uart4 transmit flag low while buffer empty");

   a_charge_clear_write: assert property
      (s_write_zero(PIF_OFS_THREE) ##0 !i_charge_time_event
         |=> !o_peripheral_flags_three[PIF_B3_CHARGE])
      else $error("charge-time flag not cleared by zero write");

   a_charge_sticky: assert property
      (o_peripheral_flags_three[PIF_B3_CHARGE] && !wr_en[0]
         |=> o_peripheral_flags_three[PIF_B3_CHARGE])
      else $error("charge-time flag dropped without a write");

   a_capcomp_set: assert property
      (i_capcomp_capture[0] && !i_capcomp_pwm_mode[0]
         |=> o_peripheral_flags_three[1])
      else $error("capture unit one flag not set on capture");

   a_capcomp_pwm_quiet: assert property
      (!o_peripheral_flags_four[0] && !wr_en[1] && i_capcomp_pwm_mode[2]
         |=> !o_peripheral_flags_four[0])
      else $error("unit three flag set in pulse-width mode");

   a_capcomp_match_ten: assert property
      (i_capcomp_match[9] && !i_capcomp_pwm_mode[9]
         |=> o_peripheral_flags_four[7])
      else $error("unit ten flag not set on compare match");

   // the lock flag shows at the edge after the change is sampled; a later
   // check could be spoiled by a clearing write landing in between
   a_lock_change_set: assert property
      ($changed(i_tuning_locked) |=> o_peripheral_flags_five[PIF_B5_LOCK])
      else $error("lock change did not set the lock flag");

   a_timer8_set: assert property
      (i_timer8_period_match |=> o_peripheral_flags_five[PIF_B5_T8])
      else $error("timer8 match did not set its flag");

   a_comparator_set: assert property
      (i_comparator_event[2] |=> o_peripheral_flags_six[2])
      else $error("comparator three event did not set its flag");

   a_reserved_zero: assert property
      (o_peripheral_flags_five[7] == 1'b0 && o_peripheral_flags_five[3] == 1'b0
         && o_peripheral_flags_six[3] == 1'b0)
      else $error("unimplemented flag bit reads one");

   a_read_data_six: assert property
      (s_read_addr(PIF_OFS_SIX) |=> o_hrdata == {24'h00_0000,
         $past(o_peripheral_flags_six)})
      else $error("read of register six returned wrong data");

endmodule // pif_flags

// >>> pif_uart_model.sv
// buffer model of the three serial ports that feed the flag block
`timescale 1ns/100ps
module pif_uart_model
#(
   parameter int TX_TIME = 8
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [2:0] i_tx_write,
   input wire logic [2:0] i_rx_arrive,
   input wire logic [2:0] i_rx_read,
   output logic [2:0] o_tx_empty,
   output logic [2:0] o_rx_full
);
   int cnt [3];
   // ---------------------------------------------
   // slot 0 is uart2, 1 uart3, 2 uart4
   // ---------------------------------------------
   always @(posedge i_clk or posedge i_rst)
   begin
      for (int u = 0; u < 3; u++)
      begin
         if (i_rst)
         begin
            o_tx_empty[u] <= 1'b1;
            o_rx_full[u] <= 1'b0;
            cnt[u] <= 0;
         end
         else
         begin
            // holding register drains after a fixed shift time
            if (i_tx_write[u])
            begin
               o_tx_empty[u] <= 1'b0;
               cnt[u] <= TX_TIME;
            end
            else if (cnt[u] > 0)
            begin
               cnt[u] <= cnt[u] - 1;
               if (cnt[u] == 1)
                  o_tx_empty[u] <= 1'b1;
            end
            if (i_rx_arrive[u])
               o_rx_full[u] <= 1'b1;
            else if (i_rx_read[u])
               o_rx_full[u] <= 1'b0;
         end
      end
   end
endmodule // pif_uart_model

// >>> testbench.sv
// self-checking testbench for the peripheral flag registers
`timescale 1ns/100ps
module testbench;
   import pif_pkg::*;
   logic clk, rst, hsel, hwrite, hready, hresp, seg, lock;
   logic [1:0] htrans;
   logic [2:0] hsize, txw, rxa, rxr, txe, rxf;
   logic [31:0] haddr, hwdata, hrdata;
   logic [30:0] ev;
   logic [9:0] pwm;
   logic [7:0] f3, f4, f5, f6;
   int fail_count, cmp_count, cyc;
   // ---------------------------------------------
   // design and far side
   // ---------------------------------------------
   pif_flags i_pif_flags (.i_clk(clk), .i_rst(rst), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
      .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
      .i_seg_write_ok(seg), .i_uart2_rx_full(rxf[0]),
      .i_uart2_tx_empty(txe[0]), .i_uart3_rx_full(rxf[1]),
      .i_uart3_tx_empty(txe[1]), .i_uart4_rx_full(rxf[2]),
      .i_uart4_tx_empty(txe[2]), .i_uart2_rx_data_read(rxr[0]),
      .i_uart2_tx_data_write(txw[0]), .i_uart3_rx_data_read(rxr[1]),
      .i_uart3_tx_data_write(txw[1]), .i_uart4_rx_data_read(rxr[2]),
      .i_uart4_tx_data_write(txw[2]), .i_charge_time_event(ev[20]),
      .i_capcomp_capture(ev[9:0]), .i_capcomp_match(ev[19:10]),
      .i_capcomp_pwm_mode(pwm), .i_tuning_out_of_range(ev[30]),
      .i_tuning_locked(lock), .i_timer8_period_match(ev[21]),
      .i_timer6_period_match(ev[22]), .i_comparator_event(ev[25:23]),
      .i_timer5_gate_event(ev[26]), .i_timer5_overflow(ev[28]),
      .i_timer4_period_match(ev[29]), .i_calendar_event(ev[27]),
      .o_peripheral_flags_three(f3), .o_peripheral_flags_four(f4),
      .o_peripheral_flags_five(f5), .o_peripheral_flags_six(f6));
   pif_uart_model i_pif_uart_model (.i_clk(clk), .i_rst(rst),
      .i_tx_write(txw), .i_rx_arrive(rxa), .i_rx_read(rxr),
      .o_tx_empty(txe), .o_rx_full(rxf));
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk8(r[7:0], e);
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, {24'h000000, d}, r);
      chk8({7'h00, hresp}, 8'h00);
   endtask
   task automatic fire(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
   endtask
   // register and bit of each event source, {reg, bit}
   function automatic logic [4:0] loc(input int i);
      int k;
      k = i % 10;
      if (i < 20)
         return (k < 2) ? {2'h0, 3'(k + 1)} : {2'h1, 3'(k - 2)};
      case (i)
         20: return {2'h0, 3'h3};
         21: return {2'h2, 3'h4};
         22: return {2'h2, 3'h2};
         23, 24, 25: return {2'h3, 3'(i - 23)};
         26: return {2'h0, 3'h7};
         27: return {2'h0, 3'h0};
         28: return {2'h2, 3'h1};
         29: return {2'h2, 3'h0};
         default: return {2'h2, 3'h6};
      endcase
   endfunction
   // idle image: transmit buffers empty, receive buffers empty
   function automatic logic [7:0] base(input logic [1:0] r);
      return (r == 2'h0) ? 8'h10 : (r == 2'h3) ? 8'h50 : 8'h00;
   endfunction
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_events;
      logic [4:0] l;
      logic [31:0] a;
      for (int i = 0; i < 31; i++)
      begin
         l = loc(i);
         a = {28'h0000000, l[4:3], 2'h0};
         fire(i);
         rd(a, base(l[4:3]) | (8'h01 << l[2:0]));
         wr(a, 8'h00);
         rd(a, base(l[4:3]));
      end
   endtask
   task automatic t_pwm;
      pwm <= 10'h3ff;
      @(posedge clk);
      ev[19:0] <= 20'hfffff;
      @(posedge clk);
      ev[19:0] <= 20'h00000;
      rd(32'h0, 8'h10);
      rd(32'h4, 8'h00);
      pwm <= 10'h000;
   endtask
   task automatic t_access;
      logic [7:0] full [4] = '{8'h9f, 8'hff, 8'h77, 8'h57};
      for (int r = 0; r < 4; r++)
      begin
         wr(32'(4 * r), 8'hff);
         rd(32'(4 * r), full[r]);
         wr(32'(4 * r), 8'h00);
         rd(32'(4 * r), base(2'(r)));
      end
      // high address bits must not alias onto a register
      wr(32'h1000, 8'hff);
      rd(32'h0, 8'h10);
      rd(32'h10, 8'h00);
   endtask
   task automatic t_seg;
      seg <= 1'b1;
      @(posedge clk);
      rd(32'h0, 8'h50);
      seg <= 1'b0;
      @(posedge clk);
      rd(32'h0, 8'h10);
   endtask
   task automatic t_lock;
      for (int n = 0; n < 2; n++)
      begin
         lock <= ~lock;
         repeat (2) @(posedge clk);
         rd(32'h8, 8'h20);
         wr(32'h8, 8'h00);
         rd(32'h8, 8'h00);
      end
   endtask
   task automatic t_uart;
      txw <= 3'h7;
      @(posedge clk);
      txw <= 3'h0;
      rd(32'h0, 8'h00);
      rd(32'hc, 8'h00);
      repeat (12) @(posedge clk);
      rd(32'h0, 8'h10);
      rd(32'hc, 8'h50);
      rxa <= 3'h7;
      @(posedge clk);
      rxa <= 3'h0;
      wr(32'h0, 8'h00);
      rd(32'h0, 8'h30);
      rd(32'hc, 8'hf0);
      rxr <= 3'h7;
      @(posedge clk);
      rxr <= 3'h0;
      rd(32'h0, 8'h10);
      rd(32'hc, 8'h50);
   endtask
   // ---------------------------------------------
   // clock, timeout and main sequence
   // ---------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         fail_count++;
         report_and_stop;
      end
   end
   initial
   begin
      {hsel, hwrite, seg, lock, htrans, txw, rxa, rxr} = '0;
      {haddr, hwdata, ev, pwm} = '0;
      hsize = 3'h2;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      chk8(f3 | f4 | f5 | f6, 8'h00);
      rst <= 1'b0;
      hsel <= 1'b1;
      for (int r = 0; r < 4; r++)
         rd(32'(4 * r), base(2'(r)));
      t_events;
      t_pwm;
      t_access;
      t_seg;
      t_lock;
      t_uart;
      report_and_stop;
   end
endmodule // testbench
